// *** logic/mrf_fir_core.v ***
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "mrf_map.vh"
// Summary of operation
// - symmetric serial adds one cycle per output
// - several sets, active set switchable live
// - inactive sets writable while filtering runs
// - factor one single-rate, else 1..16
// - coefficient width buildable from 2 to 32
// - asymmetric reload disables symmetry folding
// - reload works for every structure type
// - multicycle variable cycles from 1 to 1024
// - parallel gives one output every cycle
// - bit-serial takes data-width cycles per output
// - multibit serial divides cycles by sub-filters
// - sub-filter count must divide data width
// - channels time-share one filter
// - interpolation zero-stuffs then filters
// - decimation filters then keeps every Mth
// - polyphase branch advances once per round of channel slots since reset
// - folding pre-adds sample pairs before multiply
// - decimated output every branches times cycles
module mrf_fir_core #(
	parameter STRUCT      = `MRF_STRUCT_PAR,
	parameter TAPS        = 8,
	parameter DATA_W      = 16,
	parameter COEF_W      = 16,
	parameter SETS        = 2,
	parameter CYCLES      = 4,
	parameter SUBF        = 2,
	parameter CHANNELS    = 1,
	parameter RATE        = `MRF_RATE_SGL,
	parameter FACTOR      = 1,
	parameter SYM         = 0,
	parameter RELOAD_ASYM = 0,
	parameter PIPE        = 0
) (
	// clock and reset
	input  wire                      pclk,
	input  wire                      presetn,
	// apb slave
	input  wire                      psel,
	input  wire                      penable,
	input  wire                      pwrite,
	input  wire [`MRF_ADDR_W-1:0]    paddr,
	input  wire [31:0]               pwdata,
	output reg  [31:0]               prdata,
	output wire                      pready,
	output wire                      pslverr,
	// sample input
	input  wire                      in_valid,
	input  wire [DATA_W-1:0]         in_data,
	output wire                      in_ready,
	output wire [((CHANNELS > 1) ? $clog2(CHANNELS) : 1)-1:0] in_channel,
	// result output
	output wire                      out_valid,
	output wire [DATA_W+COEF_W+1+$clog2(TAPS):0] out_data,
	output wire [((CHANNELS > 1) ? $clog2(CHANNELS) : 1)-1:0] out_channel
);

	localparam FOLD    = (SYM != 0) && (RELOAD_ASYM == 0);
	localparam SER_LK  = (STRUCT == `MRF_STRUCT_SER) ||
	                     (STRUCT == `MRF_STRUCT_MBS);
	// cycles per output by structure
	localparam CPO_B   = (STRUCT == `MRF_STRUCT_PAR) ? 1 :
	                     (STRUCT == `MRF_STRUCT_MCV) ? CYCLES :
	                     (STRUCT == `MRF_STRUCT_SER) ? DATA_W :
	                     DATA_W / SUBF;
	localparam CPO     = CPO_B + ((FOLD && SER_LK) ? 1 : 0);
	localparam WORDS   = FOLD ? (TAPS + 1) / 2 : TAPS;
	localparam FACT    = (RATE == `MRF_RATE_SGL) ? 1 : FACTOR;
	localparam ACC_W   = DATA_W + COEF_W + 2 + $clog2(TAPS);
	localparam CNT_W   = (CPO > 1) ? $clog2(CPO) : 1;
	localparam CH_W    = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
	localparam SW      = (SETS > 1) ? $clog2(SETS) : 1;
	localparam AW      = (WORDS > 1) ? $clog2(WORDS) : 1;
	localparam PH_W    = `MRF_PH_W;
	// build legality; an illegal build never starts
	localparam CFG_OK  =
		((RATE != `MRF_RATE_SGL) || (FACTOR == 1)) &&
		(FACTOR >= `MRF_MIN_FACTOR) && (FACTOR <= `MRF_MAX_FACTOR) &&
		(COEF_W >= `MRF_MIN_COEF_W) && (COEF_W <= `MRF_MAX_COEF_W) &&
		(CYCLES >= `MRF_MIN_CYCLES) && (CYCLES <= `MRF_MAX_CYCLES) &&
		((STRUCT != `MRF_STRUCT_MBS) ||
		 ((SUBF > 0) && (DATA_W % SUBF == 0)));
	localparam [`MRF_INFO_F_W-1:0] CPO_F  = CPO;
	localparam [`MRF_INFO_F_W-1:0] TAPS_F = TAPS;
	// address match, used by read and write decode
	function match;
		input [`MRF_ADDR_W-1:0] a;
		input [`MRF_ADDR_W-1:0] off;
		match = (a == off);
	endfunction

	reg  [CNT_W-1:0]        cnt_q;
	reg  [CH_W-1:0]         ch_q, calc_ch_q;
	reg  [PH_W-1:0]         ph_q, calc_ph_q;
	reg  [SW-1:0]           act_set_q, req_set_q, load_set_q;
	reg  [AW-1:0]           caddr_q;
	reg                     refused_q, calc_q;
	reg  [DATA_W-1:0]       dl_q [0:CHANNELS*TAPS-1];
	reg  [ACC_W-1:0]        pd_q [0:PIPE];
	reg                     pv_q [0:PIPE];
	reg  [CH_W-1:0]         pc_q [0:PIPE];
	reg  signed [ACC_W-1:0] acc;
	reg  signed [DATA_W:0]  pre;
	reg  signed [DATA_W+COEF_W:0] prod;
	wire [WORDS*COEF_W-1:0] coef_q;
	wire [DATA_W-1:0]       push;
	wire                    slot_start, slot_end, shift, keep;
	wire                    wr_acc, rd_setup, cdata_wr, cdata_bad;
	integer                 t;

	assign slot_start = (cnt_q == {CNT_W{1'b0}});
	assign slot_end   = (cnt_q == CPO - 1);
	assign shift      = CFG_OK && slot_start;
	// interpolation takes a sample only on branch zero
	assign in_ready   = shift &&
	                    ((RATE != `MRF_RATE_INT) || (ph_q == 0));
	assign in_channel = ch_q;
	// zero-stuffing on the other branches
	assign push       = (in_ready && in_valid) ? in_data :
	                    {DATA_W{1'b0}};
	// slot, channel and branch counters free-run from reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= {CNT_W{1'b0}};
			ch_q  <= {CH_W{1'b0}};
			ph_q  <= {PH_W{1'b0}};
		end
		else if (CFG_OK)
		begin
			cnt_q <= slot_end ? {CNT_W{1'b0}} : cnt_q + 1'b1;
			if (slot_end)
				ch_q <= (ch_q == CHANNELS - 1) ? {CH_W{1'b0}} :
				        ch_q + 1'b1;
			if (slot_end && (ch_q == CHANNELS - 1))
				ph_q <= (ph_q == FACT - 1) ? {PH_W{1'b0}} :
				        ph_q + 1'b1;
		end
	end
	// per-channel delay lines, shifted once per slot
	genvar g;
	generate
		for (g = 0; g < CHANNELS*TAPS; g = g + 1)
		begin : g_dl
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					dl_q[g] <= {DATA_W{1'b0}};
				else if (shift && (g / TAPS == ch_q))
				begin
					if (g % TAPS == 0)
						dl_q[g] <= push;
					else
						dl_q[g] <= dl_q[g-1];
				end
			end
		end
	endgenerate

	// dot product; word k of a set weighs tap WORDS-1-k
	always @*
	begin
		acc  = {ACC_W{1'b0}};
		pre  = {(DATA_W+1){1'b0}};
		prod = {(DATA_W+COEF_W+1){1'b0}};
		for (t = 0; t < WORDS; t = t + 1)
		begin
			pre = {dl_q[calc_ch_q*TAPS+t][DATA_W-1],
			       dl_q[calc_ch_q*TAPS+t]};
			if (FOLD && (t != TAPS - 1 - t))
				pre = pre + {dl_q[calc_ch_q*TAPS+TAPS-1-t][DATA_W-1],
				             dl_q[calc_ch_q*TAPS+TAPS-1-t]};
			prod = pre * $signed(coef_q[(WORDS-1-t)*COEF_W +: COEF_W]);
			acc  = acc + {{(ACC_W-DATA_W-COEF_W-1){prod[DATA_W+COEF_W]}},
			              prod};
		end
	end

	// decimation keeps only branch zero results
	assign keep = (RATE != `MRF_RATE_DEC) || (calc_ph_q == 0);
	// result capture one cycle after the shift
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			calc_q    <= 1'b0;
			calc_ch_q <= {CH_W{1'b0}};
			calc_ph_q <= {PH_W{1'b0}};
			pd_q[0]   <= {ACC_W{1'b0}};
			pv_q[0]   <= 1'b0;
			pc_q[0]   <= {CH_W{1'b0}};
		end
		else
		begin
			calc_q <= shift;
			if (shift)
			begin
				calc_ch_q <= ch_q;
				calc_ph_q <= ph_q;
			end
			pv_q[0] <= calc_q && keep;
			if (calc_q && keep)
			begin
				pd_q[0] <= acc;
				pc_q[0] <= calc_ch_q;
			end
		end
	end
	// optional pipeline stages add latency only
	generate
		for (g = 1; g <= PIPE; g = g + 1)
		begin : g_pipe
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pd_q[g] <= {ACC_W{1'b0}};
					pv_q[g] <= 1'b0;
					pc_q[g] <= {CH_W{1'b0}};
				end
				else
				begin
					pd_q[g] <= pd_q[g-1];
					pv_q[g] <= pv_q[g-1];
					pc_q[g] <= pc_q[g-1];
				end
			end
		end
	endgenerate

	assign out_valid   = pv_q[PIPE];
	assign out_data    = pd_q[PIPE];
	assign out_channel = pc_q[PIPE];
	// apb strobes; zero wait states
	assign pready    = 1'b1;
	assign wr_acc    = psel && penable && pwrite;
	assign rd_setup  = psel && !penable && !pwrite;
	assign pslverr   = psel && penable &&
	                   !(match(paddr, `MRF_OFF_CTRL)  ||
	                     match(paddr, `MRF_OFF_CADDR) ||
	                     match(paddr, `MRF_OFF_CDATA) ||
	                     match(paddr, `MRF_OFF_STATUS) ||
	                     match(paddr, `MRF_OFF_INFO));
	assign cdata_wr  = wr_acc && match(paddr, `MRF_OFF_CDATA);
	// the set in use or about to be used is never written
	assign cdata_bad = (load_set_q == act_set_q) ||
	                   (load_set_q == req_set_q);
	// control registers and set switching
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_set_q  <= {SW{1'b0}};
			req_set_q  <= {SW{1'b0}};
			load_set_q <= {SW{1'b0}};
			caddr_q    <= {AW{1'b0}};
			refused_q  <= 1'b0;
		end
		else
		begin
			// switch only when a new output starts
			if (shift)
				act_set_q <= req_set_q;
			if (wr_acc && match(paddr, `MRF_OFF_CTRL))
			begin
				req_set_q  <= pwdata[`MRF_CTRL_ACT_LSB +: SW];
				load_set_q <= pwdata[`MRF_CTRL_LOAD_LSB +: SW];
			end
			if (wr_acc && match(paddr, `MRF_OFF_CADDR))
				caddr_q <= pwdata[AW-1:0];
			else if (cdata_wr)
				caddr_q <= (caddr_q == WORDS - 1) ? {AW{1'b0}} :
				           caddr_q + 1'b1;
			// refusal flag: a new refusal beats the clear
			if (cdata_wr && cdata_bad)
				refused_q <= 1'b1;
			else if (wr_acc && match(paddr, `MRF_OFF_STATUS) &&
			         pwdata[`MRF_ST_REFUSED_BIT])
				refused_q <= 1'b0;
		end
	end
	// read data captured in the setup cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= `MRF_RST_WORD;
		else if (rd_setup)
		begin
			prdata <= `MRF_RST_WORD;
			if (match(paddr, `MRF_OFF_CTRL))
			begin
				prdata[`MRF_CTRL_ACT_LSB +: SW]  <= req_set_q;
				prdata[`MRF_CTRL_LOAD_LSB +: SW] <= load_set_q;
			end
			else if (match(paddr, `MRF_OFF_CADDR))
				prdata[AW-1:0] <= caddr_q;
			else if (match(paddr, `MRF_OFF_STATUS))
			begin
				prdata[`MRF_ST_SET_LSB +: SW]  <= act_set_q;
				prdata[`MRF_ST_CFG_OK_BIT]     <= CFG_OK;
				prdata[`MRF_ST_REFUSED_BIT]    <= refused_q;
				prdata[`MRF_ST_PH_LSB +: PH_W] <= ph_q;
			end
			else if (match(paddr, `MRF_OFF_INFO))
			begin
				prdata[`MRF_INFO_CPO_LSB +: `MRF_INFO_F_W]  <= CPO_F;
				prdata[`MRF_INFO_TAPS_LSB +: `MRF_INFO_F_W] <= TAPS_F;
			end
		end
	end
	// coefficient sets; any structure reloads the same way
	mrf_coef_bank #(
		.SETS    (SETS),
		.WORDS   (WORDS),
		.W       (COEF_W),
		.SW      (SW),
		.AW      (AW)
	) u_bank (
		.pclk       (pclk),
		.presetn    (presetn),
		.wr_en      (cdata_wr && !cdata_bad),
		.wr_set     (load_set_q),
		.wr_word    (caddr_q),
		.wr_data    (pwdata[COEF_W-1:0]),
		.rd_set     (act_set_q),
		.rd_words_q (coef_q)
	);

endmodule // mrf_fir_core

// *** common/mrf_map.vh ***
`ifndef MRF_MAP_VH
`define MRF_MAP_VH

// structure type codes
`define MRF_STRUCT_MCV      0
`define MRF_STRUCT_PAR      1
`define MRF_STRUCT_SER      2
`define MRF_STRUCT_MBS      3

// rate mode codes
`define MRF_RATE_SGL        0
`define MRF_RATE_INT        1
`define MRF_RATE_DEC        2

// legal build ranges
`define MRF_MIN_FACTOR      1
`define MRF_MAX_FACTOR      16
`define MRF_MIN_COEF_W      2
`define MRF_MAX_COEF_W      32
`define MRF_MIN_CYCLES      1
`define MRF_MAX_CYCLES      1024

// register byte offsets
`define MRF_ADDR_W          12
`define MRF_OFF_CTRL        12'h000
`define MRF_OFF_CADDR       12'h004
`define MRF_OFF_CDATA       12'h008
`define MRF_OFF_STATUS      12'h00c
`define MRF_OFF_INFO        12'h010

// field positions
`define MRF_SETF_W          4
`define MRF_CTRL_ACT_LSB    0
`define MRF_CTRL_LOAD_LSB   8
`define MRF_CADDR_W         10
`define MRF_ST_SET_LSB      0
`define MRF_ST_CFG_OK_BIT   8
`define MRF_ST_REFUSED_BIT  9
`define MRF_ST_PH_LSB       16
`define MRF_PH_W            5
`define MRF_INFO_CPO_LSB    0
`define MRF_INFO_TAPS_LSB   16
`define MRF_INFO_F_W        16

// reset values
`define MRF_RST_WORD        32'h0000_0000

`endif

// *** logic/mrf_coef_bank.v ***
`timescale 1ns/100ps
module mrf_coef_bank #(
	parameter SETS  = 2,
	parameter WORDS = 8,
	parameter W     = 16,
	parameter SW    = 1,
	parameter AW    = 3
) (
	// clock and reset
	input  wire                 pclk,
	input  wire                 presetn,
	// write port
	input  wire                 wr_en,
	input  wire [SW-1:0]        wr_set,
	input  wire [AW-1:0]        wr_word,
	input  wire [W-1:0]         wr_data,
	// read port, whole set per cycle
	input  wire [SW-1:0]        rd_set,
	output reg  [WORDS*W-1:0]   rd_words_q
);

	reg [W-1:0] mem [0:SETS*WORDS-1];
	integer     i;

	// storage, cleared at reset so every set starts at zero
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < SETS*WORDS; i = i + 1)
				mem[i] <= {W{1'b0}};
		end
		else if (wr_en)
			mem[wr_set*WORDS+wr_word] <= wr_data;
	end

	// registered read of the set in use
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_words_q <= {(WORDS*W){1'b0}};
		else
		begin
			for (i = 0; i < WORDS; i = i + 1)
				rd_words_q[i*W +: W] <= mem[rd_set*WORDS+i];
		end
	end

endmodule // mrf_coef_bank

// *** tb/mrf_monitor.sv ***
`timescale 1ns/100ps
`include "mrf_map.vh"
module mrf_monitor #(
	parameter STRUCT = 1, CYCLES = 4, DATA_W = 16, SUBF = 2,
	parameter SYM = 0, RELOAD_ASYM = 0, CHANNELS = 1,
	parameter CH_W = 1, ACC_W = 36
) (
	// clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// apb
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [`MRF_ADDR_W-1:0] paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// stream
	input wire logic                   in_valid,
	input wire logic [DATA_W-1:0]      in_data,
	input wire logic                   in_ready,
	input wire logic [CH_W-1:0]        in_channel,
	input wire logic                   out_valid,
	input wire logic [ACC_W-1:0]       out_data,
	input wire logic [CH_W-1:0]        out_channel
);
	localparam FOLD = SYM && !RELOAD_ASYM;
	localparam SERW = STRUCT == `MRF_STRUCT_SER ? DATA_W : DATA_W / SUBF;
	localparam CPO  = STRUCT == `MRF_STRUCT_PAR ? 1 :
		STRUCT == `MRF_STRUCT_MCV ? CYCLES : SERW + FOLD;
	logic [15:0]     gap_q;
	logic            seen_q;
	logic [CH_W-1:0] last_q;
	wire bad_a = paddr > `MRF_OFF_INFO || paddr[1:0] != 2'h0;
	// cycles since in_ready was last high, channel taken then
	always_ff @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		gap_q  <= 16'h0;
		seen_q <= 1'b0;
		last_q <= '0;
	end
	else
	begin
		gap_q  <= in_ready ? 16'h0 : gap_q + 16'h1;
		seen_q <= seen_q | in_ready;
		last_q <= in_ready ? in_channel : last_q;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take; in_ready; endsequence
	sequence s_result; ##2 out_valid; endsequence
	property p_take_out; s_take |-> s_result; endproperty
	property p_out_cause; out_valid |-> $past(in_ready, 2); endproperty
	property p_ch_follow;
		out_valid |-> out_channel == $past(in_channel, 2);
	endproperty
	property p_ch_turn;
		in_ready && seen_q |->
			in_channel == (last_q == CHANNELS - 1 ? '0 : last_q + 1'b1);
	endproperty
	property p_slot; in_ready && seen_q |-> gap_q == CPO - 1; endproperty
	property p_hold; !out_valid |-> $stable(out_data); endproperty
	property p_ready; psel && penable |-> pready; endproperty
	property p_err; psel && penable |-> pslverr == bad_a; endproperty
	property p_err_data;
		psel && penable && !pwrite && bad_a |-> prdata == 32'h0;
	endproperty
	a_take_out: assert property (p_take_out)
		else $error("no result two cycles after a take");
	a_out_cause: assert property (p_out_cause)
		else $error("result without a take");
	a_ch_follow: assert property (p_ch_follow)
		else $error("result channel differs from taken channel");
	a_ch_turn: assert property (p_ch_turn)
		else $error("channels not served in turn");
	a_slot: assert property (p_slot)
		else $error("slot period wrong");
	a_hold: assert property (p_hold)
		else $error("result changed without valid");
	a_ready: assert property (p_ready)
		else $error("access without ready");
	a_err: assert property (p_err)
		else $error("error response wrong for address");
	a_err_data: assert property (p_err_data)
		else $error("unmapped read data not zero");
endmodule // mrf_monitor
bind mrf_fir_core mrf_monitor #(.STRUCT(STRUCT), .CYCLES(CYCLES),
	.DATA_W(DATA_W), .SUBF(SUBF), .SYM(SYM), .RELOAD_ASYM(RELOAD_ASYM),
	.CHANNELS(CHANNELS), .CH_W(CH_W), .ACC_W(ACC_W)) i_mrf_monitor (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .in_valid, .in_data, .in_ready,
	.in_channel, .out_valid, .out_data, .out_channel);

// *** tb/mrf_src.sv ***
`timescale 1ns/100ps
module mrf_src #(
	parameter DATA_W = 16
) (
	// clock, reset, pace
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic [1:0]    mode,
	// stream
	input wire logic          in_ready,
	output logic              in_valid,
	output logic [DATA_W-1:0] in_data
);
	integer seed = 17923;
	// new sample once the last was taken; idle data random too
	always @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		in_valid <= 1'b0;
		in_data  <= '0;
	end
	else if (!in_valid || in_ready)
	begin
		in_valid <= mode[0] || (mode[1] && $random(seed) % 2 != 0);
		in_data  <= DATA_W'($random(seed));
	end
endmodule // mrf_src

// *** tb/mrf_fir_core_test.sv ***
`timescale 1ns/100ps
`include "mrf_map.vh"
module mrf_fir_core_test;
	logic               pclk = 0, presetn = 0, err;
	logic               psel = 0, penable = 0, pwrite = 0;
	logic [11:0]        paddr = 0;
	logic [31:0]        pwdata = 0, prdata, rd;
	logic               pready, pslverr, in_valid, in_ready, out_valid;
	logic [15:0]        in_data;
	logic               in_channel, out_channel;
	logic [35:0]        out_data;
	logic [1:0]         mode = 0;
	logic signed [15:0] cs [2][4] = '{default: 0};
	logic signed [15:0] hx [2][4] = '{default: 0};
	logic signed [35:0] acc;
	logic [36:0]        q [$];
	integer             seed = 17923, num_errors = 0, checked = 0, act = 0;
	// clock
	initial
		forever #20 pclk = ~pclk;
	mrf_fir_core #(.TAPS(4), .CHANNELS(2)) i_mrf_fir_core (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .in_valid, .in_data, .in_ready, .in_channel,
		.out_valid, .out_data, .out_channel);
	mrf_src i_mrf_src (.pclk, .presetn, .mode, .in_ready, .in_valid,
		.in_data);
	task automatic chk(input logic [63:0] s, e);
		checked++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one apb transfer, waits for ready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge pclk);
		psel   <= 1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 0;
		penable <= 0;
		if (pready !== 1'b1)
		begin
			num_errors++;
			final_report;
		end
	endtask
	// reload an inactive set, words in reversed tap order
	task automatic load(input integer s);
		apb(1, `MRF_OFF_CTRL, (s << 8) | act);
		apb(1, `MRF_OFF_CADDR, 0);
		for (int k = 0; k < 4; k++)
		begin
			cs[s][k] = $random(seed);
			apb(1, `MRF_OFF_CDATA, {16'h0, cs[s][k]});
		end
	endtask
	// switch sets while the history holds only zeros
	task automatic swap(input logic [31:0] c, input integer a);
		mode <= 2'd0;
		repeat (10) @(posedge pclk);
		apb(1, `MRF_OFF_CTRL, c);
		act = a;
		repeat (10) @(posedge pclk);
	endtask
	// note the expected result of every taken sample
	always @(posedge pclk)
	if (presetn && in_ready === 1'b1)
	begin
		for (int k = 3; k > 0; k--)
			hx[in_channel][k] = hx[in_channel][k-1];
		hx[in_channel][0] = in_valid ? in_data : 16'h0;
		acc = 0;
		for (int k = 0; k < 4; k++)
			acc = acc + cs[act][k] * hx[in_channel][3-k];
		q.push_back({in_channel, acc});
	end
	// compare each result with the oldest note
	always @(posedge pclk)
	if (presetn && out_valid === 1'b1)
		if (q.size() == 0)
			chk(1, 0);
		else
			chk({out_channel, out_data}, q.pop_front());
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		apb(0, `MRF_OFF_INFO, 0);
		chk(rd, 32'h0004_0001);
		apb(0, `MRF_OFF_STATUS, 0);
		chk(rd, 32'h0000_0100);
		apb(0, 12'h020, 0);
		chk({err, rd}, {1'b1, 32'h0});
		load(1);
		mode <= 2'd1;
		repeat (20) @(posedge pclk);
		swap(32'h0000_0001, 1);
		mode <= 2'd1;
		load(0);
		mode <= 2'd2;
		repeat (30) @(posedge pclk);
		// reload into the active set is refused
		apb(1, `MRF_OFF_CTRL, 32'h0000_0101);
		apb(1, `MRF_OFF_CDATA, 32'h0000_1234);
		apb(0, `MRF_OFF_STATUS, 0);
		chk(rd, 32'h0000_0301);
		apb(1, `MRF_OFF_STATUS, 32'h0000_0200);
		apb(0, `MRF_OFF_STATUS, 0);
		chk(rd, 32'h0000_0101);
		swap(32'h0000_0000, 0);
		mode <= 2'd2;
		repeat (30) @(posedge pclk);
		chk(q.size() < 4, 1);
		final_report;
	end
endmodule // mrf_fir_core_test
